/* core/ude_pkg.sv */
// Constants, types and register map of the USB device event flag block.
// Assumes one 50 MHz clock and an AXI4-Lite master on the register side.
// Behaviour
// - Enable-set view: one enables, zero ignored.
// - Unused enable and flag bits read zero.
// - Writing one clears a flag; zero ignored.
// - LPM ACK and suspend sets bit 9.
// - LPM NYET answer sets bit 8.
// - IN-stage memory underflow sets bit 7.
// - Sending upstream resume sets bit 6.
// - Host resume end sets bit 5.
// - Filtered non-idle wake sets bit 4.
// - End of bus reset sets bit 3.
// - Start-of-frame sets bit 2, stores frame number.
// - Idle J for 3 ms sets bit 0.
// - Summary is read-only live endpoint pending bits.
// - Config byte at 0x100 plus 0x20 per endpoint.
// - Enable-clear view: one disables; views read same.
// - Direction type codes zero to five, six-seven reserved.
// - Bus reset clears types except endpoint zero.
package ude_pkg;

  localparam int NUM_EP      = 8;
  localparam int IRQ_W       = 16;
  localparam int SUMMARY_W   = 16;
  localparam int ADDR_W      = 12;
  localparam int FRAME_NUM_W = 11;

  localparam logic [ADDR_W-1:0] OFF_FRAME_NUM  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_EN_CLR     = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_EN_SET     = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_FLAGS      = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_SUMMARY    = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_EPCFG_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] EPCFG_SPAN     = 12'h100;

  localparam int BIT_SUSPEND  = 0;
  localparam int BIT_SOF      = 2;
  localparam int BIT_BUS_RST  = 3;
  localparam int BIT_WAKE     = 4;
  localparam int BIT_HOST_RSM = 5;
  localparam int BIT_UP_RSM   = 6;
  localparam int BIT_UNDERRUN = 7;
  localparam int BIT_LPM_NYET = 8;
  localparam int BIT_LPM_ACK  = 9;

  localparam logic [IRQ_W-1:0] IRQ_VALID_MASK = 16'h03fd;
  localparam logic [IRQ_W-1:0] ENABLE_RST     = 16'h0000;
  localparam logic [IRQ_W-1:0] FLAGS_RST      = 16'h0000;
  localparam logic [7:0]       EPCFG_RST      = 8'h00;
  localparam logic [7:0]       EPCFG_MASK     = 8'h77;

  localparam int CLK_FREQ_KHZ        = 50000;
  localparam int SUSPEND_IDLE_MS     = 3;
  localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_MS * CLK_FREQ_KHZ;
  localparam int WAKE_FILTER_CYCLES  = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    EP_DISABLED    = 3'h0,
    EP_CONTROL     = 3'h1,
    EP_ISOCHRONOUS = 3'h2,
    EP_BULK        = 3'h3,
    EP_INTERRUPT   = 3'h4,
    EP_DUAL_BANK   = 3'h5,
    EP_RSVD6       = 3'h6,
    EP_RSVD7       = 3'h7
  } ude_ep_type_t;

  typedef struct packed {
    logic         rsvdHi;
    ude_ep_type_t inDirType;
    logic         rsvdLo;
    ude_ep_type_t outDirType;
  } ude_ep_cfg_t;

  typedef struct packed {
    logic lpmAckSuspended;
    logic lpmNotYetAnswered;
    logic memoryUnderflowError;
    logic remoteResumeSent;
    logic hostResumeDone;
  } ude_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } ude_wreq_t;

endpackage

/* core/ude_sync2.sv */
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module ude_sync2
  import ude_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic meta_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_r  <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* core/ude_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes decode and read data are answered combinationally by the parent.
`timescale 1ns/100ps
`default_nettype none
module ude_axil_slave
  import ude_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output ude_pkg::ude_wreq_t     wrReq,
  output logic                   wrEn,
  input  wire logic              wrErr,
  output logic [ADDR_W-1:0]      rdAddr,
  input  wire logic [31:0]       rdData,
  input  wire logic              rdErr
);
  logic awHeld_r;
  logic wHeld_r;

  assign awready = ~awHeld_r;
  assign wready  = ~wHeld_r;
  assign arready = ~rvalid;
  assign rdAddr  = araddr;
  assign wrEn    = awHeld_r & wHeld_r & ~bvalid;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      wrReq    <= '0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r   <= 1'b1;
        wrReq.addr <= awaddr;
      end
      else if (wrEn)
        awHeld_r <= 1'b0;
      if (wvalid && wready)
      begin
        wHeld_r    <= 1'b1;
        wrReq.data <= wdata;
        wrReq.strb <= wstrb;
      end
      else if (wrEn)
        wHeld_r <= 1'b0;
      if (wrEn)
      begin
        bvalid <= 1'b1;
        bresp  <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rdData;
        rresp  <= rdErr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/ude_event_flags.sv */
// Device event flags, interrupt enables, endpoint summary and endpoint
// configuration bytes of a full-speed USB device controller.
// Assumes event strobes come from the packet engine on mclk; the idle-J
// line indication comes from a pin and is synchronised here.
// Wake-up is only filtered while the link is suspended.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ude_event_flags
  import ude_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_IDLE_CYCLES
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [ADDR_W-1:0]      awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [ADDR_W-1:0]      araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire ude_pkg::ude_events_t   devEvents,
  input  wire logic                   sofDetected,
  input  wire logic [FRAME_NUM_W-1:0] sofFrameNum,
  input  wire logic                   busResetActive,
  input  wire logic                   lineIdleJ,
  input  wire logic [SUMMARY_W-1:0]   epPendingBits,
  output ude_pkg::ude_ep_cfg_t        epConfig [NUM_EP],
  output logic [FRAME_NUM_W-1:0]      frameNumber,
  output logic                        linkSuspended,
  output logic                        irq
);

  typedef enum logic {
    LINK_ACTIVE,
    LINK_SUSPENDED
  } ude_link_state_t;

  localparam logic [17:0] SUSP_LAST = 18'(SUSPEND_CYCLES - 1);
  localparam logic [2:0]  WAKE_LAST = 3'(WAKE_FILTER_CYCLES - 1);

  // Bus front end
  ude_wreq_t         wrReq;
  logic              wrEn;
  logic              wrErr;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdData;
  logic              rdErr;

  ude_axil_slave u_axil
  (
    .mclk    (mclk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrReq   (wrReq),
    .wrEn    (wrEn),
    .wrErr   (wrErr),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .rdErr   (rdErr)
  );

  // Idle-J pin into the clock domain
  logic idleJ;

  ude_sync2 u_sync_idle
  (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (lineIdleJ),
    .syncOut (idleJ)
  );

  // State
  logic [IRQ_W-1:0]       enable_r;
  logic [IRQ_W-1:0]       enable_nxt;
  logic [IRQ_W-1:0]       flags_r;
  logic [IRQ_W-1:0]       flags_nxt;
  logic [SUMMARY_W-1:0]   summary_r;
  logic [FRAME_NUM_W-1:0] frame_r;
  logic                   busRstDly_r;
  logic [17:0]            idleCnt_r;
  logic [17:0]            idleCnt_nxt;
  logic [2:0]             wakeCnt_r;
  logic [2:0]             wakeCnt_nxt;
  ude_link_state_t        link_r;
  ude_link_state_t        link_nxt;
  ude_ep_cfg_t            cfg_r   [NUM_EP];
  ude_ep_cfg_t            cfg_nxt [NUM_EP];
  logic                   suspendEv;
  logic                   wakeEv;

  // Write decode
  logic [ADDR_W-1:0] cfgOff;
  logic [2:0]        wrIdx;
  logic              wrCfgRange;
  logic              wrHitEnClr;
  logic              wrHitEnSet;
  logic              wrHitFlags;
  logic              wrHitRo;
  logic              wrHitCfg;
  logic [IRQ_W-1:0]  wrBits;
  logic [7:0]        wrByte;

  assign cfgOff     = wrReq.addr - OFF_EPCFG_BASE;
  assign wrIdx      = cfgOff[7:5];
  assign wrCfgRange = (wrReq.addr >= OFF_EPCFG_BASE) && (cfgOff < EPCFG_SPAN)
                      && (cfgOff[4:0] == 5'h00);
  assign wrHitEnClr = wrReq.addr == OFF_EN_CLR;
  assign wrHitEnSet = wrReq.addr == OFF_EN_SET;
  assign wrHitFlags = wrReq.addr == OFF_FLAGS;
  assign wrHitRo    = (wrReq.addr == OFF_SUMMARY) || (wrReq.addr == OFF_FRAME_NUM);
  assign wrHitCfg   = wrCfgRange;
  assign wrErr      = ~(wrHitEnClr | wrHitEnSet | wrHitFlags | wrHitRo | wrHitCfg);
  assign wrBits     = {wrReq.data[15:8] & {8{wrReq.strb[1]}},
                       wrReq.data[7:0] & {8{wrReq.strb[0]}}}
                      & IRQ_VALID_MASK;
  assign wrByte     = wrReq.data[7:0] & {8{wrReq.strb[0]}} & EPCFG_MASK;

  // Enable registers: one set, one clear view
  logic [IRQ_W-1:0] setMask;
  logic [IRQ_W-1:0] clrMask;

  assign setMask    = (wrEn && wrHitEnSet) ? wrBits : '0;
  assign clrMask    = (wrEn && wrHitEnClr) ? wrBits : '0;
  assign enable_nxt = ((enable_r | setMask) & ~clrMask) & IRQ_VALID_MASK;

  // Hardware events
  logic [IRQ_W-1:0] evSet;
  logic [IRQ_W-1:0] flagClr;
  logic             busRstDoneEv;

  assign busRstDoneEv = busRstDly_r & ~busResetActive;

  always_comb
  begin
    evSet               = '0;
    evSet[BIT_LPM_ACK]  = devEvents.lpmAckSuspended;
    evSet[BIT_LPM_NYET] = devEvents.lpmNotYetAnswered;
    evSet[BIT_UNDERRUN] = devEvents.memoryUnderflowError;
    evSet[BIT_UP_RSM]   = devEvents.remoteResumeSent;
    evSet[BIT_HOST_RSM] = devEvents.hostResumeDone;
    evSet[BIT_WAKE]     = wakeEv;
    evSet[BIT_BUS_RST]  = busRstDoneEv;
    evSet[BIT_SOF]      = sofDetected;
    evSet[BIT_SUSPEND]  = suspendEv;
  end

  // A same-cycle event outlives a software clear
  assign flagClr   = (wrEn && wrHitFlags) ? wrBits : '0;
  assign flags_nxt = ((flags_r & ~flagClr) | evSet) & IRQ_VALID_MASK;

  // Suspend detection and filtered wake-up
  always_comb
  begin
    link_nxt    = link_r;
    idleCnt_nxt = '0;
    wakeCnt_nxt = '0;
    suspendEv   = 1'b0;
    wakeEv      = 1'b0;
    unique case (link_r)
      LINK_ACTIVE:
      begin
        if (devEvents.lpmAckSuspended)
          link_nxt = LINK_SUSPENDED;
        else if (idleJ && !busResetActive)
        begin
          if (idleCnt_r == SUSP_LAST)
          begin
            suspendEv = 1'b1;
            link_nxt  = LINK_SUSPENDED;
          end
          else
            idleCnt_nxt = idleCnt_r + 18'h00001;
        end
      end
      LINK_SUSPENDED:
      begin
        if (!idleJ)
        begin
          if (wakeCnt_r == WAKE_LAST)
          begin
            wakeEv   = 1'b1;
            link_nxt = LINK_ACTIVE;
          end
          else
            wakeCnt_nxt = wakeCnt_r + 3'h1;
        end
      end
    endcase
  end

  // Endpoint configuration bytes
  always_comb
  begin
    for (int i = 0; i < NUM_EP; i++)
    begin
      cfg_nxt[i] = cfg_r[i];
      if (wrEn && wrHitCfg && (wrIdx == 3'(i)))
        cfg_nxt[i] = ude_ep_cfg_t'(wrByte);
      if (busResetActive && (i != 0))
        cfg_nxt[i] = ude_ep_cfg_t'(EPCFG_RST);
    end
  end

  // Interrupt enables and event flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      enable_r <= ENABLE_RST;
      flags_r  <= FLAGS_RST;
    end
    else
    begin
      enable_r <= enable_nxt;
      flags_r  <= flags_nxt;
    end
  end

  // Level interrupt, registered together with the flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(flags_nxt & enable_nxt);
    end
  end

  // Frame number and endpoint summary copies
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      summary_r <= '0;
      frame_r   <= '0;
    end
    else
    begin
      summary_r <= epPendingBits;
      if (sofDetected)
        frame_r <= sofFrameNum;
    end
  end

  // Link state, idle and wake counters, bus reset edge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      busRstDly_r <= 1'b0;
      idleCnt_r   <= '0;
      wakeCnt_r   <= '0;
      link_r      <= LINK_ACTIVE;
    end
    else
    begin
      busRstDly_r <= busResetActive;
      idleCnt_r   <= idleCnt_nxt;
      wakeCnt_r   <= wakeCnt_nxt;
      link_r      <= link_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NUM_EP; i++)
    begin
      if (rst)
        cfg_r[i] <= ude_ep_cfg_t'(EPCFG_RST);
      else
        cfg_r[i] <= cfg_nxt[i];
    end
  end

  // Read decode
  logic [ADDR_W-1:0] rdOff;
  logic [2:0]        rdIdx;
  logic              rdHitEn;
  logic              rdHitFlags;
  logic              rdHitSummary;
  logic              rdHitFrame;
  logic              rdHitCfg;
  logic [7:0]        rdCfgByte;

  assign rdOff        = rdAddr - OFF_EPCFG_BASE;
  assign rdIdx        = rdOff[7:5];
  assign rdHitEn      = (rdAddr == OFF_EN_SET) || (rdAddr == OFF_EN_CLR);
  assign rdHitFlags   = rdAddr == OFF_FLAGS;
  assign rdHitSummary = rdAddr == OFF_SUMMARY;
  assign rdHitFrame   = rdAddr == OFF_FRAME_NUM;
  assign rdHitCfg     = (rdAddr >= OFF_EPCFG_BASE) && (rdOff < EPCFG_SPAN)
                        && (rdOff[4:0] == 5'h00);
  assign rdCfgByte    = 8'(cfg_r[rdIdx]) & EPCFG_MASK;
  assign rdErr        = ~(rdHitEn | rdHitFlags | rdHitSummary | rdHitFrame | rdHitCfg);
  assign rdData       = rdHitEn      ? {16'h0000, enable_r & IRQ_VALID_MASK} :
                        rdHitFlags   ? {16'h0000, flags_r & IRQ_VALID_MASK} :
                        rdHitSummary ? {16'h0000, summary_r} :
                        rdHitFrame   ? {21'h000000, frame_r} :
                        rdHitCfg     ? {24'h000000, rdCfgByte} :
                        32'h00000000;

  // Outputs
  assign frameNumber   = frame_r;
  assign linkSuspended = link_r == LINK_SUSPENDED;

  always_comb
  begin
    for (int i = 0; i < NUM_EP; i++)
      epConfig[i] = cfg_r[i];
  end

endmodule
`default_nettype wire

/* bench/ude_event_flags_properties.sv */
// Port-level assertions for the device event flag block.
// Assumes it is bound onto every ude_event_flags instance.
`timescale 1ns/100ps
`default_nettype none
module ude_event_flags_properties
  import ude_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = 20
)
(
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic                   arvalid,
  input wire logic                   arready,
  input wire logic                   rvalid,
  input wire logic                   rready,
  input wire ude_pkg::ude_events_t   devEvents,
  input wire logic                   sofDetected,
  input wire logic [FRAME_NUM_W-1:0] sofFrameNum,
  input wire logic                   busResetActive,
  input wire ude_pkg::ude_ep_cfg_t   epConfig [NUM_EP],
  input wire logic [FRAME_NUM_W-1:0] frameNumber,
  input wire logic                   linkSuspended
);
  logic cfgHiBusy;
  logic cfgRsvd;
  // Any non-zero config above endpoint zero, any reserved bit set
  always_comb
  begin
    cfgHiBusy = 1'b0;
    cfgRsvd   = 1'b0;
    for (int i = 0; i < NUM_EP; i++)
    begin
      if (i > 0)
        cfgHiBusy = cfgHiBusy | (|epConfig[i]);
      cfgRsvd = cfgRsvd | epConfig[i].rsvdHi | epConfig[i].rsvdLo;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_sof_frame: assert property (sofDetected |=> frameNumber == $past(sofFrameNum))
    else $error("frame number not loaded by SOF");
  chk_frame_hold: assert property (!sofDetected |=> $stable(frameNumber))
    else $error("frame number moved without SOF");
  chk_cfg_cleared: assert property (busResetActive |=> !cfgHiBusy)
    else $error("endpoint config kept during bus reset");
  chk_cfg_rsvd: assert property (!cfgRsvd)
    else $error("reserved config bit set");
  chk_lpm_suspend: assert property (devEvents.lpmAckSuspended |=> linkSuspended)
    else $error("LPM ACK did not suspend");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_read_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  chk_write_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
endmodule
bind ude_event_flags ude_event_flags_properties #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) chk (
  .mclk, .rst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .rready, .devEvents, .sofDetected, .sofFrameNum, .busResetActive, .epConfig,
  .frameNumber, .linkSuspended);
`default_nettype wire

/* bench/ude_host_model.sv */
// Behavioural far side: packet engine strobes and bus line state.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/100ps
`default_nettype none
module ude_host_model
  import ude_pkg::*;
(
  input  wire logic              mclk,
  output ude_pkg::ude_events_t   devEvents,
  output logic                   sofDetected,
  output logic [FRAME_NUM_W-1:0] sofFrameNum,
  output logic                   busResetActive,
  output logic                   lineIdleJ
);
  initial
  begin
    devEvents      = '0;
    sofDetected    = 1'b0;
    sofFrameNum    = '1;
    busResetActive = 1'b0;
    lineIdleJ      = 1'b0;
  end
  // One-cycle event strobe
  task automatic strobe(input int k);
    @(posedge mclk);
    devEvents[k] <= 1'b1;
    @(posedge mclk);
    devEvents <= '0;
  endtask
  // Frame number valid only with the strobe
  task automatic sof(input logic [FRAME_NUM_W-1:0] n);
    @(posedge mclk);
    sofDetected <= 1'b1;
    sofFrameNum <= n;
    @(posedge mclk);
    sofDetected <= 1'b0;
    sofFrameNum <= ~n;
  endtask
  task automatic busReset(input int c);
    @(posedge mclk);
    busResetActive <= 1'b1;
    repeat (c) @(posedge mclk);
    busResetActive <= 1'b0;
    @(posedge mclk);
  endtask
  // Idle J level held for a span
  task automatic lineLevel(input logic j, input int c);
    @(posedge mclk);
    lineIdleJ <= j;
    repeat (c) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the device event flag block.
// Assumes a short suspend count and an AXI4-Lite master driven here.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ude_pkg::*;
  localparam int SUSP = 20;
  logic mclk = 1'b0;
  logic rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, sofDetected, busResetActive, lineIdleJ, linkSuspended, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, w, en, m;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wResp, rResp;
  logic [FRAME_NUM_W-1:0] sofFrameNum, frameNumber, fn;
  logic [SUMMARY_W-1:0] epPendingBits;
  ude_events_t devEvents;
  ude_ep_cfg_t epConfig [NUM_EP];
  int fail_count = 0;
  int checked = 0;
  int order [9] = '{0, 1, 2, 3, 5, 6, 7, 8, 4};

  always #10 mclk = ~mclk;

  ude_event_flags #(.SUSPEND_CYCLES(SUSP)) DUT (
    .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .devEvents,
    .sofDetected, .sofFrameNum, .busResetActive, .lineIdleJ, .epPendingBits, .epConfig,
    .frameNumber, .linkSuspended, .irq);
  ude_host_model host (.mclk, .devEvents, .sofDetected, .sofFrameNum, .busResetActive, .lineIdleJ);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic axWrite(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    wResp = bresp;
  endtask
  task automatic axRead(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    rResp = rresp;
  endtask
  function automatic logic [31:0] flagMask(input int k);
    int b;
    b = (k < 5) ? k + 5 : (k == 5) ? 2 : (k == 6) ? 3 : (k == 7) ? 0 : 4;
    return 32'h1 << b;
  endfunction
  function automatic logic [7:0] cfgByte(input int n);
    return {1'b0, 3'(n), 1'b0, 3'(7 - n)};
  endfunction
  task automatic fire(input int k);
    case (k)
      5: host.sof(fn);
      6: host.busReset(5);
      7: host.lineLevel(1'b1, SUSP + 8);
      8: host.lineLevel(1'b0, 10);
      default: host.strobe(k);
    endcase
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    close_out();
  end

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    epPendingBits = '0;
    void'($urandom(32'h3e0d23f6));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    foreach (order[i])
    begin
      axRead(i < 5 ? 12'h010 + 12'(4 * i) : OFF_EPCFG_BASE, d);
      check(d, 32'h0);
    end
    en = '0;
    repeat (6)
    begin
      w = $urandom & IRQ_VALID_MASK;
      axWrite(OFF_EN_SET, w);
      en = en | w;
      w = $urandom & IRQ_VALID_MASK;
      axWrite(OFF_EN_CLR, w);
      en = en & ~w;
      axRead(OFF_EN_SET, d);
      check(d, en);
      axRead(OFF_EN_CLR, d);
      check(d, en);
    end
    repeat (3)
    begin
      w = 32'(16'($urandom));
      epPendingBits <= w[15:0];
      axWrite(OFF_SUMMARY, ~w);
      check(wResp, RESP_OKAY);
      axRead(OFF_SUMMARY, d);
      check(d, w);
    end
    for (int n = 0; n < NUM_EP; n++)
      axWrite(OFF_EPCFG_BASE + 12'(32 * n), 32'(cfgByte(n)));
    for (int n = 0; n < NUM_EP; n++)
    begin
      axRead(OFF_EPCFG_BASE + 12'(32 * n), d);
      check(d, 32'(cfgByte(n) & EPCFG_MASK));
    end
    foreach (order[i])
    begin
      m = flagMask(order[i]);
      fn = 11'($urandom);
      axWrite(OFF_FLAGS, IRQ_VALID_MASK);
      axWrite(OFF_EN_CLR, IRQ_VALID_MASK);
      axWrite(OFF_EN_SET, m);
      fire(order[i]);
      axRead(OFF_FLAGS, d);
      check(d & m, m);
      check(irq, 1'b1);
      if (order[i] == 7 || order[i] == 8)
        check(linkSuspended, order[i] == 7);
      if (order[i] == 5)
      begin
        axRead(OFF_FRAME_NUM, d);
        check(d, 32'(fn));
      end
      axWrite(OFF_EN_CLR, m);
      axWrite(OFF_FLAGS, IRQ_VALID_MASK & ~m);
      axRead(OFF_FLAGS, d);
      check(d & m, m);
      check(irq, 1'b0);
      axWrite(OFF_FLAGS, m);
      axWrite(OFF_EN_SET, m);
      axRead(OFF_FLAGS, d);
      check(d & m, 32'h0);
      check(irq, 1'b0);
    end
    // Event strobe sampled on the edge that applies a clear of all flags
    fork
      axWrite(OFF_FLAGS, IRQ_VALID_MASK);
      begin
        @(posedge mclk);
        host.strobe(0);
      end
    join
    axRead(OFF_FLAGS, d);
    check(d, flagMask(0));
    for (int n = 0; n < NUM_EP; n++)
    begin
      axRead(OFF_EPCFG_BASE + 12'(32 * n), d);
      check(d, n == 0 ? 32'(cfgByte(0) & EPCFG_MASK) : 32'h0);
    end
    axRead(12'h0fc, d);
    check(rResp, RESP_SLVERR);
    axWrite(12'h004, 32'h1);
    check(wResp, RESP_SLVERR);
    close_out();
  end
endmodule
`default_nettype wire
